/* File: include/carrier_pkg.sv */
`default_nettype none
package carrier_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int LOW_HZ = 500;
    localparam int MID_HZ = 1000;
    localparam int HIGH_HZ = 2000;
    localparam int LOW_DIV = CLK_HZ / LOW_HZ;
    localparam int MID_DIV = CLK_HZ / MID_HZ;
    localparam int HIGH_DIV = CLK_HZ / HIGH_HZ;
    localparam int DIV_W = 17;
    localparam int STANDBY_MM = 84;
    localparam int UM_PER_STEP = 100;
    localparam int STANDBY_STEPS = (STANDBY_MM * 1000) / UM_PER_STEP;
    localparam int POS_W = 16;
    localparam int SENSOR_COUNT = 8;
    localparam int SX_PROX = 0;
    localparam int SX_STOP1 = 1;
    localparam int SX_STOP2 = 2;
    localparam int SZ_UP_HOME = 3;
    localparam int SZ_UP_LIMIT = 4;
    localparam int SZ_LO_HOME = 5;
    localparam int SZ_LO_LIMIT = 6;
    localparam int SZ_MIDDLE = 7;
    localparam logic [1:0] SPD_LOW = 2'h0;
    localparam logic [1:0] SPD_MID = 2'h1;
    localparam logic [1:0] SPD_HIGH = 2'h2;
    localparam logic SEL_HORIZ = 1'b1;
    localparam logic SEL_VERT = 1'b0;

    typedef enum logic [2:0] {
        OP_START, OP_DRAIN_LIFT, OP_AGITATE, OP_NORMAL, OP_HOME
    } vop_t;

    typedef struct packed {
        logic stop1_slit;
        logic stop2_slit;
        logic right_side;
        logic approach;
        logic centre;
        logic horiz_home;
        logic up_home;
        logic up_limit;
        logic lo_home;
        logic lo_limit;
        logic middle;
    } pos_t;

    typedef struct packed {
        logic req;
        logic horiz;
        logic dir;
        vop_t op;
        logic [POS_W-1:0] steps;
    } move_t;
endpackage : carrier_pkg
`default_nettype wire

/* File: rtl/sensor_sync.sv */
`default_nettype none
module sensor_sync #(
    parameter int N = carrier_pkg::SENSOR_COUNT
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [N-1:0] raw_i,
    output logic [N-1:0] sync_o
);
    import carrier_pkg::*;
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
    } sync_state_t;
    sync_state_t st_r;
    sync_state_t st_nxt;
    if (N != SENSOR_COUNT) begin : g_bad_width
        $error("sensor_sync serves exactly eight inputs");
    end
    always_comb begin
        st_nxt.s1 = raw_i;
        st_nxt.s2 = st_r.s1;
    end
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign sync_o = st_r.s2;
endmodule : sensor_sync
`default_nettype wire

/* File: rtl/step_gen.sv */
`default_nettype none
module step_gen (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [1:0] speed_i,
    input wire logic [carrier_pkg::POS_W-1:0] steps_i,
    output logic step_o,
    output logic busy_o
);
    import carrier_pkg::*;
    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [POS_W-1:0] left;
        logic [1:0] speed;
        logic step;
        logic busy;
    } gen_state_t;
    gen_state_t st_r;
    gen_state_t st_nxt;
    logic [DIV_W-1:0] half;
    always_comb begin
        unique case (st_r.speed)
            SPD_MID: half = DIV_W'(MID_DIV / 2);
            SPD_HIGH: half = DIV_W'(HIGH_DIV / 2);
            default: half = DIV_W'(LOW_DIV / 2);
        endcase
    end
    always_comb begin
        st_nxt = st_r;
        if (!st_r.busy) begin
            st_nxt.step = 1'b0;
            if (start_i && steps_i != '0) begin
                st_nxt.busy = 1'b1;
                st_nxt.left = steps_i;
                st_nxt.speed = speed_i;
                st_nxt.div = '0;
            end
        end else if (st_r.div >= half - DIV_W'(1)) begin
            st_nxt.div = '0;
            st_nxt.step = ~st_r.step;
            if (st_r.step) begin
                st_nxt.left = st_r.left - POS_W'(1);
                if (st_r.left == POS_W'(1)) begin
                    st_nxt.busy = 1'b0;
                end
            end
        end else begin
            st_nxt.div = st_r.div + DIV_W'(1);
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign step_o = st_r.step;
    assign busy_o = st_r.busy;
endmodule : step_gen
`default_nettype wire

/* File: rtl/carrier_position_decoder.sv */
`default_nettype none
module carrier_position_decoder (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [carrier_pkg::SENSOR_COUNT-1:0] sensor_i,
    input wire carrier_pkg::move_t move_i,
    input wire logic basket_held_i,
    output logic move_ack_o,
    output logic move_refused_o,
    output logic step_o,
    output logic axis_sel_o,
    output logic dir_o,
    output logic busy_o,
    output carrier_pkg::pos_t pos_o,
    output logic [carrier_pkg::POS_W-1:0] horiz_count_o,
    output logic [carrier_pkg::POS_W-1:0] vert_from_home_o,
    output logic standby_ok_o,
    output logic home_go_up_o
);
    import carrier_pkg::*;

    // ==========================================================
    // State
    typedef enum logic [2:0] {
        ST_IDLE, ST_PRE_VERT, ST_PRE_WAIT, ST_RUN, ST_WAIT
    } phase_t;

    typedef struct packed {
        phase_t phase;
        move_t cmd;
        logic sel;
        logic dir;
        logic [1:0] speed;
        logic gen_start;
        logic [POS_W-1:0] gen_steps;
        logic ack;
        logic refused;
        logic step_q;
        logic [POS_W-1:0] hcount;
        logic [POS_W-1:0] vcount;
        pos_t pos;
        logic standby_ok;
        logic go_up;
        logic busy;
    } top_state_t;

    top_state_t st_r;
    top_state_t st_nxt;
    logic [SENSOR_COUNT-1:0] sens;
    logic gen_step;
    logic gen_busy;
    logic at_travel_height;
    logic need_up;
    logic [POS_W-1:0] dist_home;
    logic [POS_W-1:0] dist_standby;

    // ==========================================================
    // Sensor synchroniser and step pulse generator
    sensor_sync #(.N(SENSOR_COUNT)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .raw_i(sensor_i),
        .sync_o(sens)
    );

    step_gen u_gen (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .start_i(st_r.gen_start),
        .speed_i(st_r.speed),
        .steps_i(st_r.gen_steps),
        .step_o(gen_step),
        .busy_o(gen_busy)
    );

    // ==========================================================
    // Travel height choice
    always_comb begin
        dist_home = st_r.vcount;
        if (st_r.vcount >= POS_W'(STANDBY_STEPS)) begin
            dist_standby = st_r.vcount - POS_W'(STANDBY_STEPS);
        end else begin
            dist_standby = POS_W'(STANDBY_STEPS) - st_r.vcount;
        end
        at_travel_height = st_r.pos.up_home || st_r.pos.lo_home
            || st_r.pos.up_limit || st_r.pos.lo_limit
            || (st_r.standby_ok && st_r.vcount == POS_W'(STANDBY_STEPS));
        need_up = 1'b1;
        if (!basket_held_i && dist_standby < dist_home) begin
            need_up = (st_r.vcount > POS_W'(STANDBY_STEPS));
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.gen_start = 1'b0;
        st_nxt.ack = 1'b0;
        st_nxt.refused = 1'b0;
        st_nxt.step_q = gen_step && (st_r.sel == SEL_HORIZ || st_r.sel == SEL_VERT);

        st_nxt.pos.right_side = sens[SX_PROX];
        st_nxt.pos.stop1_slit = ~sens[SX_STOP1];
        st_nxt.pos.stop2_slit = ~sens[SX_STOP2];
        st_nxt.pos.approach = ~sens[SX_STOP1] & sens[SX_STOP2];
        st_nxt.pos.centre = ~sens[SX_STOP1] & ~sens[SX_STOP2];
        st_nxt.pos.horiz_home = ~sens[SX_STOP1] & ~sens[SX_STOP2] & ~sens[SX_PROX];
        st_nxt.pos.up_home = sens[SZ_UP_HOME];
        st_nxt.pos.up_limit = sens[SZ_UP_LIMIT];
        st_nxt.pos.lo_home = sens[SZ_LO_HOME];
        st_nxt.pos.lo_limit = sens[SZ_LO_LIMIT];
        st_nxt.pos.middle = sens[SZ_MIDDLE];
        st_nxt.go_up = ~sens[SZ_MIDDLE];
        st_nxt.standby_ok = ~basket_held_i;

        // Falling step edge marks one finished pulse.
        if (st_r.step_q && !gen_step) begin
            if (st_r.sel == SEL_HORIZ) begin
                if (st_r.dir) begin
                    st_nxt.hcount = st_r.hcount + POS_W'(1);
                end else begin
                    st_nxt.hcount = st_r.hcount - POS_W'(1);
                end
            end else begin
                if (st_r.dir) begin
                    st_nxt.vcount = st_r.vcount - POS_W'(1);
                end else begin
                    st_nxt.vcount = st_r.vcount + POS_W'(1);
                end
            end
        end
        if (st_r.pos.horiz_home) begin
            st_nxt.hcount = '0;
        end
        if (st_r.pos.up_home || st_r.pos.lo_home) begin
            st_nxt.vcount = '0;
        end

        unique case (st_r.phase)
            ST_IDLE: begin
                if (move_i.req) begin
                    st_nxt.cmd = move_i;
                    if (move_i.horiz) begin
                        if (at_travel_height) begin
                            st_nxt.phase = ST_RUN;
                        end else begin
                            st_nxt.phase = ST_PRE_VERT;
                        end
                        st_nxt.ack = 1'b1;
                    end else if ((basket_held_i && !st_r.pos.centre)
                        || (!basket_held_i && !st_r.pos.approach
                        && move_i.op != OP_HOME)) begin
                        st_nxt.refused = 1'b1;
                    end else begin
                        st_nxt.phase = ST_RUN;
                        st_nxt.ack = 1'b1;
                    end
                end
            end
            ST_PRE_VERT: begin
                st_nxt.sel = SEL_VERT;
                st_nxt.dir = need_up;
                st_nxt.speed = SPD_HIGH;
                st_nxt.gen_steps = need_up
                    ? (dist_standby < dist_home && !basket_held_i ? dist_standby : dist_home)
                    : dist_standby;
                st_nxt.gen_start = 1'b1;
                st_nxt.phase = ST_PRE_WAIT;
            end
            ST_PRE_WAIT: begin
                if (!st_r.gen_start && !gen_busy) begin
                    st_nxt.phase = ST_RUN;
                end
            end
            ST_RUN: begin
                st_nxt.sel = st_r.cmd.horiz ? SEL_HORIZ : SEL_VERT;
                st_nxt.dir = st_r.cmd.horiz ? st_r.cmd.dir
                    : (st_r.cmd.op == OP_HOME ? st_r.go_up : st_r.cmd.dir);
                if (st_r.cmd.horiz) begin
                    st_nxt.speed = SPD_HIGH;
                end else begin
                    unique case (st_r.cmd.op)
                        OP_START: st_nxt.speed = SPD_LOW;
                        OP_DRAIN_LIFT: st_nxt.speed = SPD_LOW;
                        OP_AGITATE: st_nxt.speed = SPD_MID;
                        default: st_nxt.speed = SPD_HIGH;
                    endcase
                end
                st_nxt.gen_steps = st_r.cmd.steps;
                st_nxt.gen_start = 1'b1;
                st_nxt.phase = ST_WAIT;
            end
            ST_WAIT: begin
                if (!st_r.gen_start && !gen_busy) begin
                    st_nxt.phase = ST_IDLE;
                end
            end
            default: st_nxt.phase = ST_IDLE;
        endcase
        st_nxt.busy = (st_nxt.phase != ST_IDLE);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.phase <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign move_ack_o = st_r.ack;
    assign move_refused_o = st_r.refused;
    assign step_o = st_r.step_q;
    assign axis_sel_o = st_r.sel;
    assign dir_o = st_r.dir;
    assign busy_o = st_r.busy;
    assign pos_o = st_r.pos;
    assign horiz_count_o = st_r.hcount;
    assign vert_from_home_o = st_r.vcount;
    assign standby_ok_o = st_r.standby_ok;
    assign home_go_up_o = st_r.go_up;
endmodule : carrier_position_decoder
`default_nettype wire

/* File: verification/carrier_position_decoder_asserts.sv */
`default_nettype none
module carrier_position_decoder_asserts (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [carrier_pkg::SENSOR_COUNT-1:0] sensor_i,
    input wire logic basket_held_i,
    input wire logic move_ack_o,
    input wire logic move_refused_o,
    input wire logic step_o,
    input wire logic axis_sel_o,
    input wire logic busy_o,
    input wire carrier_pkg::pos_t pos_o,
    input wire logic [carrier_pkg::POS_W-1:0] horiz_count_o,
    input wire logic standby_ok_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import carrier_pkg::*;
    // ==========================================================
    // Helpers
    // Counts edges since reset so the three-stage sensor path is full.
    logic [1:0] live_r;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) live_r <= 2'h0;
        else if (live_r != 2'h3) live_r <= live_r + 2'h1;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // Properties
    property p_approach; pos_o.approach == (pos_o.stop1_slit && !pos_o.stop2_slit); endproperty
    a_approach: assert property (p_approach) else $error("approach decode wrong");
    property p_centre; pos_o.centre == (pos_o.stop1_slit && pos_o.stop2_slit); endproperty
    a_centre: assert property (p_centre) else $error("centre decode wrong");
    property p_home; pos_o.horiz_home |-> pos_o.centre && !pos_o.right_side; endproperty
    a_home: assert property (p_home) else $error("home decode wrong");
    property p_stop1;
        live_r == 2'h3 |-> pos_o.stop1_slit == !$past(sensor_i[SX_STOP1], 3);
    endproperty
    a_stop1: assert property (p_stop1) else $error("stop one sync wrong");
    property p_prox;
        live_r == 2'h3 |-> pos_o.right_side == $past(sensor_i[SX_PROX], 3);
    endproperty
    a_prox: assert property (p_prox) else $error("proximity decode wrong");
    property p_uphome;
        live_r == 2'h3 |-> pos_o.up_home == $past(sensor_i[SZ_UP_HOME], 3);
    endproperty
    a_uphome: assert property (p_uphome) else $error("upper home decode wrong");
    property p_standby; $rose(basket_held_i) |-> ##[0:4] !standby_ok_o; endproperty
    a_standby: assert property (p_standby) else $error("standby kept with basket");
    property p_hcount;
        $fell(step_o) && axis_sel_o == SEL_VERT && !$past(pos_o.horiz_home)
            |-> $stable(horiz_count_o);
    endproperty
    a_hcount: assert property (p_hcount) else $error("count moved on vertical");
    property p_sel; $changed(step_o) |-> $stable(axis_sel_o); endproperty
    a_sel: assert property (p_sel) else $error("axis changed with step");
    property p_refuse; move_refused_o |-> !move_ack_o && !busy_o; endproperty
    a_refuse: assert property (p_refuse) else $error("refused move started");
    property p_idle; !busy_o |-> !$rose(step_o); endproperty
    a_idle: assert property (p_idle) else $error("step while idle");
    c_ack: cover property (move_ack_o);
    c_refused: cover property (move_refused_o);
    c_vstep: cover property ($rose(step_o) && axis_sel_o == SEL_VERT);
endmodule // carrier_position_decoder_asserts
bind carrier_position_decoder carrier_position_decoder_asserts u_chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sensor_i(sensor_i), .basket_held_i(basket_held_i),
    .move_ack_o(move_ack_o), .move_refused_o(move_refused_o), .step_o(step_o),
    .axis_sel_o(axis_sel_o), .busy_o(busy_o), .pos_o(pos_o),
    .horiz_count_o(horiz_count_o), .standby_ok_o(standby_ok_o));
`default_nettype wire

/* File: verification/sensor_motor_model.sv */
`default_nettype none
module sensor_motor_model (
    input wire logic sys_clk_i,
    input wire logic step_i,
    input wire logic axis_sel_i,
    input wire logic [carrier_pkg::SENSOR_COUNT-1:0] pattern_i,
    output logic [carrier_pkg::SENSOR_COUNT-1:0] sensor_o,
    output int vsteps_o,
    output int hsteps_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Sensors and motors
    // Eight identical sensor lines, each high while its beam is blocked.
    assign sensor_o = pattern_i;
    logic step_r;
    initial begin
        step_r = 1'b0;
        vsteps_o = 0;
        hsteps_o = 0;
    end
    // Only the selected motor sees the shared step line.
    always @(posedge sys_clk_i) begin
        step_r <= step_i;
        if (step_i && !step_r) begin
            if (axis_sel_i) hsteps_o <= hsteps_o + 1;
            else vsteps_o <= vsteps_o + 1;
        end
    end
endmodule // sensor_motor_model
`default_nettype wire

/* File: verification/carrier_position_decoder_tb_top.sv */
`default_nettype none
module carrier_position_decoder_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import carrier_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic basket_held_i = 1'b0;
    logic [7:0] pattern = 8'hFF;
    logic [7:0] sensor_i;
    move_t move_i = '0;
    logic move_ack_o, move_refused_o, step_o, axis_sel_o, dir_o, busy_o;
    logic standby_ok_o, home_go_up_o, acked, refd;
    pos_t pos_o;
    logic [POS_W-1:0] horiz_count_o, vert_from_home_o, hc0;
    int err_total = 0;
    int checks_done = 0;
    int vs, hs, vs0, hs0, hi;
    logic [31:0] seed = 32'h8FDA6B0F;
    always #12.5 sys_clk_i = ~sys_clk_i;
    carrier_position_decoder DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sensor_i(sensor_i),
        .move_i(move_i), .basket_held_i(basket_held_i), .move_ack_o(move_ack_o),
        .move_refused_o(move_refused_o), .step_o(step_o), .axis_sel_o(axis_sel_o),
        .dir_o(dir_o), .busy_o(busy_o), .pos_o(pos_o), .horiz_count_o(horiz_count_o),
        .vert_from_home_o(vert_from_home_o), .standby_ok_o(standby_ok_o),
        .home_go_up_o(home_go_up_o));
    sensor_motor_model u_far (.sys_clk_i(sys_clk_i), .step_i(step_o), .axis_sel_i(axis_sel_o),
        .pattern_i(pattern), .sensor_o(sensor_i), .vsteps_o(vs), .hsteps_o(hs));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic pos_t exp_pos(logic [7:0] s);
        pos_t p;
        p.stop1_slit = !s[SX_STOP1];
        p.stop2_slit = !s[SX_STOP2];
        p.right_side = s[SX_PROX];
        p.approach = p.stop1_slit && !p.stop2_slit;
        p.centre = p.stop1_slit && p.stop2_slit;
        p.horiz_home = p.centre && !s[SX_PROX];
        p.up_home = s[SZ_UP_HOME];
        p.up_limit = s[SZ_UP_LIMIT];
        p.lo_home = s[SZ_LO_HOME];
        p.lo_limit = s[SZ_LO_LIMIT];
        p.middle = s[SZ_MIDDLE];
        return p;
    endfunction
    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Lets the sensor path settle, then holds a one-step request and collects the answer.
    task automatic issue(vop_t op, logic horiz);
        repeat (4) @(negedge sys_clk_i);
        move_i <= '{1'b1, horiz, 1'b1, op, 16'h0001};
        acked = 1'b0;
        refd = 1'b0;
        repeat (4) begin
            @(negedge sys_clk_i);
            acked |= move_ack_o;
            refd |= move_refused_o;
        end
        move_i.req <= 1'b0;
    endtask
    // Applies a reset in mid-run and checks that the move is abandoned.
    task automatic mid_reset();
        rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        rst_i = 1'b0;
        chk("busy_rst", 1'b0, busy_o);
        chk("axis_rst", SEL_VERT, axis_sel_o);
        chk("step_rst", 1'b0, step_o);
    endtask
    // One-step vertical request, then waits for the move to end.
    task automatic do_move(vop_t op);
        issue(op, 1'b0);
        hi = 0;
        repeat (60000) begin
            @(negedge sys_clk_i);
            if (step_o === 1'b1) hi++;
            if (busy_o === 1'b0) break;
        end
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (90000) @(posedge sys_clk_i);
        err_total++;
        $display("Error watchdog expected done seen hang");
        test_done();
    end
    initial begin
        repeat (20) @(negedge sys_clk_i);
        rst_i = 1'b0;
        chk("busy", 1'b0, busy_o);
        for (int i = 0; i < 16; i++) begin
            pattern = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : (i == 2) ? 8'hF8 : 8'(xs());
            basket_held_i = 1'(xs() & 32'h1);
            repeat (4) @(negedge sys_clk_i);
            chk("pos", exp_pos(pattern), pos_o);
            chk("go_up", !pattern[SZ_MIDDLE], home_go_up_o);
            chk("standby", !basket_held_i, standby_ok_o);
        end
        $display("decode test done");
        pattern = 8'hF9;
        basket_held_i = 1'b0;
        do_move(OP_NORMAL);
        chk("refused", 2'h1, {acked, refd});
        pattern = 8'hFD;
        basket_held_i = 1'b1;
        do_move(OP_NORMAL);
        chk("refused", 2'h1, {acked, refd});
        $display("refusal test done");
        pattern = 8'hF9;
        for (int k = 0; k < 2; k++) begin
            vs0 = vs;
            hs0 = hs;
            hc0 = horiz_count_o;
            do_move(k ? OP_AGITATE : OP_NORMAL);
            chk("ack", 2'h2, {acked, refd});
            chk("half_period", (k ? MID_DIV : HIGH_DIV) / 2, hi);
            chk("vsteps", 1, vs - vs0);
            chk("hsteps", 0, hs - hs0);
            chk("axis", SEL_VERT, axis_sel_o);
            chk("dir", 1'b1, dir_o);
            chk("hcount", hc0, horiz_count_o);
            chk("vcount", 16'h0000, vert_from_home_o);
        end
        $display("move test done");
        // Drain lift runs at low speed: no step within a mid-speed half period.
        issue(OP_DRAIN_LIFT, 1'b0);
        chk("drain_ack", 2'h2, {acked, refd});
        hi = 0;
        repeat (MID_DIV / 2 + 100) begin
            @(negedge sys_clk_i);
            if (step_o !== 1'b0) hi++;
        end
        chk("low_speed", 0, hi);
        chk("low_busy", 1'b1, busy_o);
        mid_reset();
        // Horizontal move from a travel height selects the horizontal axis at once.
        hs0 = hs;
        issue(OP_NORMAL, 1'b1);
        chk("horiz_ack", 2'h2, {acked, refd});
        chk("horiz_axis", SEL_HORIZ, axis_sel_o);
        chk("horiz_dir", 1'b1, dir_o);
        mid_reset();
        chk("horiz_steps", 0, hs - hs0);
        $display("speed and abort test done");
        test_done();
    end
endmodule // carrier_position_decoder_tb_top
`default_nettype wire
